/* File: design/int_event_sense.v */
// Purpose: Edge detection on the external pin and change detection on the sense pins
// Assumes: Pins synchronous to clock
// Notes: Pulses are combinational, one cycle wide
`timescale 1ns/10ps

module int_event_sense (
	input wire clock,
	input wire rst,
	input wire extIntPin,
	input wire [3:0] changeSensePins,
	input wire extEdgeSelect,
	output wire extEdge,
	output wire portChange
);

	reg extPrev_ff;
	reg [3:0] sensePrev_ff;
	reg primed_ff;

	// ****************************************
	// Previous samples
	// ****************************************
	// First cycle after reset only captures, so reset values fake no event
	always @(posedge clock) begin
		if (rst) begin
			extPrev_ff <= 1'b0;
			sensePrev_ff <= 4'h0;
			primed_ff <= 1'b0;
		end else begin
			extPrev_ff <= extIntPin;
			sensePrev_ff <= changeSensePins;
			primed_ff <= 1'b1;
		end
	end

	assign extEdge = primed_ff & (extEdgeSelect ? (extIntPin & ~extPrev_ff)
		: (~extIntPin & extPrev_ff));
	assign portChange = primed_ff & (|(changeSensePins ^ sensePrev_ff));

endmodule

/* File: design/mcu_interrupt_logic.v */
// Purpose: Interrupt gathering, vectoring and sleep wake-up of an 8-bit core
// Assumes: One clock per instruction cycle; core obeys coreHold, pushEn and pcLoad
// Notes: Registers on classic Wishbone, 32-bit words, data in bits 7:0
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "mcu_int_regs.vh"

module mcu_interrupt_logic #(
	parameter PC_WIDTH = 13
) (
	input wire clock,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [4:2] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire extIntPin,
	input wire [3:0] changeSensePins,
	input wire timer0Overflow,
	input wire adcDone,
	input wire timer1Overflow,
	input wire timer2Match,
	input wire capCmpEvent,
	input wire serialEvent,
	input wire displayEvent,
	input wire instrBoundary,
	input wire [PC_WIDTH-1:0] returnPc,
	input wire returnFromIsr,
	input wire sleepEnter,
	output wire intRequest,
	output wire coreHold,
	output wire pushEn,
	output reg [PC_WIDTH-1:0] pushAddr,
	output wire pcLoad,
	output wire [PC_WIDTH-1:0] pcLoadAddr,
	output reg sleeping,
	output reg wakeUp
);

	localparam ST_RUN = 2'd0;
	localparam ST_HOLD = 2'd1;
	localparam ST_VECTOR = 2'd2;
	localparam ST_WAKE = 2'd3;

	reg [7:0] intCtrl_ff;
	reg [7:0] nxt_intCtrl;
	reg [5:0] periphFlag_ff;
	reg [5:0] nxt_periphFlag;
	reg [5:0] periphEn_ff;
	reg edgeSelect_ff;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg nxt_sleeping;
	reg nxt_wakeUp;
	reg inService_ff;
	reg sleepSkipped_ff;
	reg nxt_sleepSkipped;
	reg [7:0] readByte;

	wire extEdge;
	wire portChange;
	wire wbReq;
	wire wbWrite;
	wire [5:0] periphEvents;
	wire directHit;
	wire periphHit;
	wire wakeCond;

	// ****************************************
	// Helpers
	// ****************************************
	// Any flag with its enable also set
	function pairHit;
		input [5:0] flags;
		input [5:0] enables;
		begin
			pairHit = |(flags & enables);
		end
	endfunction

	// ****************************************
	// Event sensing
	// ****************************************
	int_event_sense u_sense (
		.clock(clock),
		.rst(rst),
		.extIntPin(extIntPin),
		.changeSensePins(changeSensePins),
		.extEdgeSelect(edgeSelect_ff),
		.extEdge(extEdge),
		.portChange(portChange)
	);

	assign periphEvents = {displayEvent, serialEvent, capCmpEvent,
		timer2Match, timer1Overflow, adcDone};

	// ****************************************
	// Request gathering
	// ****************************************
	assign directHit = pairHit({3'b000, intCtrl_ff[`BIT_TIMER0_FLAG],
		intCtrl_ff[`BIT_EXT_FLAG], intCtrl_ff[`BIT_PORT_CHG_FLAG]},
		{3'b000, intCtrl_ff[`BIT_TIMER0_EN], intCtrl_ff[`BIT_EXT_EN],
		intCtrl_ff[`BIT_PORT_CHG_EN]});
	assign periphHit = intCtrl_ff[`BIT_PERIPH_GROUP_EN]
		& pairHit(periphFlag_ff, periphEn_ff);
	assign wakeCond = directHit | periphHit;
	assign intRequest = intCtrl_ff[`BIT_GLOBAL_EN] & wakeCond;

	// ****************************************
	// Wishbone slave
	// ****************************************
	assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wbWrite = wbReq & wb_we_i & wb_sel_i[0];

	always @* begin
		case (wb_adr_i)
			`ADR_INT_CTRL: begin
				readByte = intCtrl_ff;
			end
			`ADR_PERIPH_FLAG: begin
				readByte = {2'b00, periphFlag_ff};
			end
			`ADR_PERIPH_EN: begin
				readByte = {2'b00, periphEn_ff};
			end
			`ADR_OPTION: begin
				readByte = {1'b0, edgeSelect_ff, 6'b000000};
			end
			`ADR_STATUS: begin
				readByte = {3'b000, sleepSkipped_ff, inService_ff, wakeCond,
					sleeping, intRequest};
			end
			default: begin
				readByte = 8'h00;
			end
		endcase
	end

	// One wait state; unmapped words read zero and ignore writes
	always @(posedge clock) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wbReq;
			if (wbReq) begin
				wb_dat_o <= {24'h000000, readByte};
			end
		end
	end

	// ****************************************
	// Control register update
	// ****************************************
	// Hardware set wins over a software clear in the same cycle
	always @* begin
		nxt_intCtrl = intCtrl_ff;
		if (wbWrite && wb_adr_i == `ADR_INT_CTRL) begin
			nxt_intCtrl = wb_dat_i[7:0];
		end
		if (returnFromIsr) begin
			nxt_intCtrl[`BIT_GLOBAL_EN] = 1'b1;
		end
		if (state_ff == ST_VECTOR) begin
			nxt_intCtrl[`BIT_GLOBAL_EN] = 1'b0;
		end
		nxt_intCtrl[`BIT_EXT_FLAG] = nxt_intCtrl[`BIT_EXT_FLAG] | extEdge;
		nxt_intCtrl[`BIT_TIMER0_FLAG] = nxt_intCtrl[`BIT_TIMER0_FLAG]
			| timer0Overflow;
		nxt_intCtrl[`BIT_PORT_CHG_FLAG] = nxt_intCtrl[`BIT_PORT_CHG_FLAG]
			| portChange;
	end

	always @* begin
		nxt_periphFlag = periphFlag_ff;
		if (wbWrite && wb_adr_i == `ADR_PERIPH_FLAG) begin
			nxt_periphFlag = wb_dat_i[5:0];
		end
		nxt_periphFlag = nxt_periphFlag | periphEvents;
	end

	// Flags stay set until software clears them; no hardware clear exists
	always @(posedge clock) begin
		if (rst) begin
			intCtrl_ff <= `RST_INT_CTRL;
			periphFlag_ff <= `RST_PERIPH;
			periphEn_ff <= `RST_PERIPH;
			edgeSelect_ff <= `RST_EDGE_SELECT;
		end else begin
			intCtrl_ff <= nxt_intCtrl;
			periphFlag_ff <= nxt_periphFlag;
			if (wbWrite && wb_adr_i == `ADR_PERIPH_EN) begin
				periphEn_ff <= wb_dat_i[5:0];
			end
			if (wbWrite && wb_adr_i == `ADR_OPTION) begin
				edgeSelect_ff <= wb_dat_i[`BIT_EDGE_SELECT];
			end
		end
	end

	// ****************************************
	// Vectoring and sleep sequencer
	// ****************************************
	// While awake, hold is entered the cycle after the flag sets, whatever the instruction
	// length, so latency from pin to vector stays fixed; a wake from sleep first waits for instrBoundary
	always @* begin
		nxt_state = state_ff;
		nxt_sleeping = sleeping;
		nxt_wakeUp = 1'b0;
		nxt_sleepSkipped = sleepSkipped_ff;
		case (state_ff)
			ST_RUN: begin
				if (sleeping) begin
					if (wakeCond) begin
						nxt_sleeping = 1'b0;
						nxt_wakeUp = 1'b1;
						if (intCtrl_ff[`BIT_GLOBAL_EN]) begin
							nxt_state = ST_WAKE;
						end
					end
				end else if (intRequest) begin
					nxt_state = ST_HOLD;
				end else if (sleepEnter) begin
					// Pending enabled source turns the sleep into a no-op
					if (wakeCond) begin
						nxt_sleepSkipped = 1'b1;
					end else begin
						nxt_sleeping = 1'b1;
						nxt_sleepSkipped = 1'b0;
					end
				end
			end
			ST_HOLD: begin
				nxt_state = ST_VECTOR;
			end
			ST_VECTOR: begin
				nxt_state = ST_RUN;
			end
			ST_WAKE: begin
				// Instruction after the sleep runs before the vector
				if (instrBoundary) begin
					nxt_state = intRequest ? ST_HOLD : ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	always @(posedge clock) begin
		if (rst) begin
			state_ff <= ST_RUN;
			sleeping <= 1'b0;
			wakeUp <= 1'b0;
			sleepSkipped_ff <= 1'b0;
			inService_ff <= 1'b0;
			pushAddr <= {PC_WIDTH{1'b0}};
		end else begin
			state_ff <= nxt_state;
			sleeping <= nxt_sleeping;
			wakeUp <= nxt_wakeUp;
			sleepSkipped_ff <= nxt_sleepSkipped;
			if (state_ff == ST_HOLD) begin
				pushAddr <= returnPc;
			end
			if (state_ff == ST_VECTOR) begin
				inService_ff <= 1'b1;
			end else if (returnFromIsr) begin
				inService_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Core handshake
	// ****************************************
	assign coreHold = (state_ff == ST_HOLD);
	assign pushEn = (state_ff == ST_VECTOR);
	assign pcLoad = (state_ff == ST_VECTOR);
	assign pcLoadAddr = `VECTOR_ADDR;

endmodule

/* File: pkg/mcu_int_regs.vh */
// Purpose: Register map, field positions and reset values of the interrupt logic
// Assumes: 32-bit Wishbone data, one aligned word per register, data in bits 7:0
// Notes: Definitions only
`ifndef MCU_INT_REGS_VH
`define MCU_INT_REGS_VH

// ****************************************
// Word offsets (byte address = 4 x index)
// ****************************************
`define ADR_INT_CTRL 3'h0
`define ADR_PERIPH_FLAG 3'h1
`define ADR_PERIPH_EN 3'h2
`define ADR_OPTION 3'h3
`define ADR_STATUS 3'h4

// ****************************************
// Interrupt control register fields
// ****************************************
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_GROUP_EN 6
`define BIT_TIMER0_EN 5
`define BIT_EXT_EN 4
`define BIT_PORT_CHG_EN 3
`define BIT_TIMER0_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PORT_CHG_FLAG 0

// ****************************************
// Peripheral flag and enable fields
// ****************************************
`define BIT_ADC_DONE 0
`define BIT_TIMER1_OVF 1
`define BIT_TIMER2_MATCH 2
`define BIT_CAPCMP 3
`define BIT_SERIAL 4
`define BIT_DISPLAY 5
`define PERIPH_WIDTH 6

// ****************************************
// Option and status fields
// ****************************************
`define BIT_EDGE_SELECT 6
`define BIT_STAT_REQUEST 0
`define BIT_STAT_SLEEPING 1
`define BIT_STAT_WAKE_COND 2
`define BIT_STAT_IN_SERVICE 3
`define BIT_STAT_SLEEP_SKIPPED 4

// ****************************************
// Reset values and vector
// ****************************************
`define RST_INT_CTRL 8'h00
`define RST_PERIPH 6'h00
`define RST_EDGE_SELECT 1'b1
`define VECTOR_ADDR 13'h0004

`endif

/* File: verification/core_model.sv */
// Purpose: Program counter side of the core
// Assumes: One instruction per cycle
// Notes: Boundary every second cycle, so waits are slow
`timescale 1ns/10ps
module core_model (
	input wire clock,
	input wire rst,
	input wire coreHold,
	input wire pcLoad,
	input wire [12:0] pcLoadAddr,
	output reg [12:0] returnPc,
	output wire instrBoundary
);
	// ****************
	// Sequencer
	// ****************
	assign instrBoundary = returnPc[0];
	always @(posedge clock) begin
		if (rst) begin
			returnPc <= 13'h0100;
		end else if (pcLoad) begin
			returnPc <= pcLoadAddr;
		end else if (!coreHold) begin
			returnPc <= returnPc + 13'h0001;
		end
	end
endmodule

/* File: verification/mcu_int_checker_assertions.sv */
// Purpose: Port-level checks of the interrupt logic
// Assumes: Bound to the top module
// Notes: One clock domain
`timescale 1ns/10ps
module mcu_int_checker #(
	parameter PC_WIDTH = 13
) (
	input wire clock,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire extIntPin,
	input wire [PC_WIDTH-1:0] returnPc,
	input wire intRequest,
	input wire coreHold,
	input wire pushEn,
	input wire [PC_WIDTH-1:0] pushAddr,
	input wire pcLoad,
	input wire [PC_WIDTH-1:0] pcLoadAddr,
	input wire sleeping,
	input wire wakeUp
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence pinUp;
		$rose(extIntPin) ##1 $rose(intRequest);
	endsequence
	sequence entry;
		coreHold ##1 (pushEn && pcLoad);
	endsequence
	a_pin_latency: assert property (pinUp |-> ##2 pcLoad)
		else $error("pin to vector latency wrong");
	a_req_entry: assert property ($rose(intRequest) && !sleeping && !wakeUp |=> entry)
		else $error("request not taken at once");
	a_vector_addr: assert property (pcLoad |-> pcLoadAddr == 13'h0004)
		else $error("vector address wrong");
	a_push_pc: assert property (pushEn |-> pcLoad && pushAddr == $past(returnPc))
		else $error("pushed address wrong");
	a_gie_off: assert property (pushEn |=> !intRequest)
		else $error("global enable not cleared");
	a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus answer late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_wake_pulse: assert property (wakeUp |-> $past(sleeping) && !sleeping)
		else $error("wake without sleep");
	a_no_vec_asleep: assert property (sleeping |-> !coreHold && !pcLoad)
		else $error("vectoring while asleep");
endmodule
bind mcu_interrupt_logic mcu_int_checker #(.PC_WIDTH(PC_WIDTH)) i_mcu_int_checker (
	.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .extIntPin(extIntPin), .returnPc(returnPc),
	.intRequest(intRequest), .coreHold(coreHold), .pushEn(pushEn), .pushAddr(pushAddr),
	.pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .sleeping(sleeping), .wakeUp(wakeUp));

/* File: verification/mcu_interrupt_logic_tb.sv */
// Purpose: Self-checking bench of the interrupt logic
// Assumes: Register map of mcu_int_regs.vh
// Notes: Event pulses one cycle wide
`timescale 1ns/10ps
`include "mcu_int_regs.vh"
module mcu_interrupt_logic_tb;
	// ****************
	// Harness
	// ****************
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg cyc, stb, we, pin, rfi, se;
	reg [2:0] adr;
	reg [31:0] dat, rv;
	reg [6:0] ev;
	reg [3:0] chg;
	wire ack, irq, hold, push, load, slp, wake, ib;
	wire [31:0] rdat;
	wire [12:0] rpc, pa, la;
	int failures = 0;
	int check_count = 0;
	always #25 clock = ~clock;
	mcu_interrupt_logic i_mcu_interrupt_logic (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .extIntPin(pin), .changeSensePins(chg),
		.timer0Overflow(ev[0]), .adcDone(ev[1]), .timer1Overflow(ev[2]), .timer2Match(ev[3]),
		.capCmpEvent(ev[4]), .serialEvent(ev[5]), .displayEvent(ev[6]), .instrBoundary(ib),
		.returnPc(rpc), .returnFromIsr(rfi), .sleepEnter(se), .intRequest(irq),
		.coreHold(hold), .pushEn(push), .pushAddr(pa), .pcLoad(load), .pcLoadAddr(la),
		.sleeping(slp), .wakeUp(wake));
	core_model i_core_model (.clock(clock), .rst(rst), .coreHold(hold), .pcLoad(load),
		.pcLoadAddr(la), .returnPc(rpc), .instrBoundary(ib));
	task final_report;
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] s);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task wb(input [2:0] a, input w, input [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h000000, d};
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		// A bus that never answers is a mismatch, not a silent pass
		if (ack !== 1'b1) begin
			failures++;
			$display("[ERR] bus ack exp 1 got %b", ack);
		end
		rv = rdat;
		{cyc, stb, we} <= 3'h0;
	endtask
	task rd(input string n, input [2:0] a, input [31:0] e);
		wb(a, 1'b0, 8'h00);
		chk(n, e, rv);
	endtask
	task pulse(input int i);
		@(posedge clock);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev <= 7'h00;
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_reset;
		rd("ctrl", `ADR_INT_CTRL, 32'h00000000);
		rd("option", `ADR_OPTION, 32'h00000040);
		rd("pen", `ADR_PERIPH_EN, 32'h00000000);
		rd("unmapped", 3'h7, 32'h00000000);
	endtask
	task t_flags;
		int i;
		pulse(0);
		chg <= 4'h5;
		for (i = 1; i < 7; i++) pulse(i);
		rd("ctrl", `ADR_INT_CTRL, 32'h00000005);
		chk("irq", 32'h00000000, {31'h0, irq});
		rd("pflag", `ADR_PERIPH_FLAG, 32'h0000003F);
		wb(`ADR_PERIPH_FLAG, 1'b1, 8'h00);
		rd("pflag", `ADR_PERIPH_FLAG, 32'h00000000);
		wb(`ADR_INT_CTRL, 1'b1, 8'h00);
	endtask
	task t_ext;
		wb(`ADR_INT_CTRL, 1'b1, 8'h90);
		pin <= 1'b1;
		repeat (6) @(posedge clock);
		rd("ctrl", `ADR_INT_CTRL, 32'h00000012);
		wb(`ADR_INT_CTRL, 1'b1, 8'h10);
		rfi <= 1'b1;
		@(posedge clock);
		rfi <= 1'b0;
		rd("ctrl", `ADR_INT_CTRL, 32'h00000090);
		wb(`ADR_OPTION, 1'b1, 8'h00);
		wb(`ADR_INT_CTRL, 1'b1, 8'h10);
		pin <= 1'b0;
		repeat (3) @(posedge clock);
		rd("ctrl", `ADR_INT_CTRL, 32'h00000012);
		chk("irq", 32'h00000000, {31'h0, irq});
		wb(`ADR_INT_CTRL, 1'b1, 8'h92);
		repeat (3) @(posedge clock);
		rd("ctrl", `ADR_INT_CTRL, 32'h00000012);
		wb(`ADR_INT_CTRL, 1'b1, 8'h00);
	endtask
	task t_group;
		wb(`ADR_PERIPH_EN, 1'b1, 8'h01);
		wb(`ADR_INT_CTRL, 1'b1, 8'h80);
		pulse(1);
		@(posedge clock);
		chk("irq", 32'h00000000, {31'h0, irq});
		wb(`ADR_INT_CTRL, 1'b1, 8'hC0);
		repeat (3) @(posedge clock);
		rd("ctrl", `ADR_INT_CTRL, 32'h00000040);
		wb(`ADR_PERIPH_FLAG, 1'b1, 8'h00);
	endtask
	task t_sleep;
		wb(`ADR_INT_CTRL, 1'b1, 8'h20);
		se <= 1'b1;
		@(posedge clock);
		se <= 1'b0;
		@(posedge clock);
		chk("sleep", 32'h00000001, {31'h0, slp});
		pulse(0);
		repeat (2) @(posedge clock);
		chk("sleep", 32'h00000000, {31'h0, slp});
		rd("ctrl", `ADR_INT_CTRL, 32'h00000024);
		// Pending enabled flag, still in service from the last vector
		rd("status", `ADR_STATUS, 32'h0000000C);
		se <= 1'b1;
		@(posedge clock);
		se <= 1'b0;
		@(posedge clock);
		chk("sleep", 32'h00000000, {31'h0, slp});
		rd("status", `ADR_STATUS, 32'h0000001C);
	endtask
	initial begin
		{cyc, stb, we, pin, rfi, se} = 6'h00;
		{adr, dat, ev, chg} = 46'h0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_flags;
		t_ext;
		t_group;
		t_sleep;
		final_report;
	end
	// Far above the run length
	initial begin
		#150000;
		failures++;
		final_report;
	end
endmodule
